// File: sps_pkg.sv
`default_nettype none

package sps_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_CONTROL = 8'hbc;
  localparam logic [7:0] ADDR_STATUS  = 8'hbd;
  localparam logic [7:0] ADDR_DATA    = 8'hbe;

  // Reset values.
  localparam logic [7:0] CONTROL_RST  = 8'h00;
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // Control register fields.
  localparam int unsigned CTL_ENABLE  = 7;
  localparam int unsigned CTL_MASTER  = 6;
  localparam int unsigned CTL_CLOCK_POLARITY    = 5;
  localparam int unsigned CTL_CLOCK_PHASE    = 4;
  localparam int unsigned CTL_SELECT_DISABLE   = 3;
  localparam int unsigned CTL_ORDER   = 2;
  localparam int unsigned CTL_RATE_HI = 1;
  localparam int unsigned CTL_RATE_LO = 0;

  // Status register fields; bits 1 and 0 read as zero.
  localparam int unsigned STA_DONE    = 7;
  localparam int unsigned STA_WRITE_COLLISION_FLAG    = 6;
  localparam int unsigned STA_MODE_FAULT_FLAG    = 5;
  localparam int unsigned STA_OVF     = 4;
  localparam int unsigned STA_RBF     = 3;
  localparam int unsigned STA_BUSY    = 2;

  // Framing: eight bits, sixteen serial clock edges per byte in master mode.
  localparam int unsigned DATA_W      = 8;
  localparam logic [2:0]  LAST_BIT    = 3'h7;
  localparam logic [3:0]  LAST_EDGE   = 4'hf;

  // Rate divider: half period of the serial clock is 2**rate system clocks.
  localparam int unsigned RATE_W      = 2;
  localparam int unsigned DIV_CNT_W   = 4;

  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } sps_state_t;

endpackage : sps_pkg

`default_nettype wire

// File: sps_rate_gen.sv
`timescale 1ns/100ps
`default_nettype none

module sps_rate_gen
  import sps_pkg::*;
#(
  parameter int unsigned RW = RATE_W,
  parameter int unsigned CW = DIV_CNT_W
) (
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst,
  // Control
  input  wire logic          run,
  input  wire logic [RW-1:0] rate,
  // Half period strobe
  output logic               tick
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] half_m1;

  if (CW < (2 ** RW) - 1) begin : g_bad_width
    $error("sps_rate_gen: counter too narrow for the rate field");
  end

  function automatic logic [CW-1:0] half_minus_one(input logic [RW-1:0] r);
    logic [CW:0] one;
    one = (CW+1)'(1);
    return CW'((one << r) - one);
  endfunction : half_minus_one

  assign half_m1 = half_minus_one(rate);

  // Count restarts whenever the shifter stops, so every byte starts with a full half period.
  always_ff @(posedge sys_clk) begin
    if (rst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q == half_m1) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick = run && (cnt_q == half_m1);

endmodule : sps_rate_gen

`default_nettype wire

// File: sps_port.sv
`timescale 1ns/100ps
`default_nettype none

module sps_port
  import sps_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Interrupt
  input  wire logic       int_enable,
  input  wire logic       int_ack,
  output logic            irq,
  // Serial clock pin
  input  wire logic       sck_i,
  output logic            sck_o,
  output logic            sck_oe,
  // Master out pin
  input  wire logic       mosi_i,
  output logic            mosi_o,
  output logic            mosi_oe,
  // Master in pin
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe,
  // Slave select pin
  input  wire logic       ss_n_i
);

  logic [7:0]        ctl_q;
  logic [7:0]        rxbuf_q;
  logic [7:0]        sr_q;
  logic              dout_q;
  logic              sck_lvl_q;
  logic              sck_prev_q;
  logic [3:0]        edge_q;
  logic [2:0]        bit_q;
  sps_state_t        state_q;
  logic              done_flag_q;
  logic              write_collision_flag_q;
  logic              mode_fault_flag_q;
  logic              ovf_q;
  logic              rbf_q;

  logic              enable;
  logic              master;
  logic              clock_polarity;
  logic              clock_phase;
  logic              select_disable;
  logic              lsb_first;
  logic [RATE_W-1:0] rate;
  logic              ctl_wr;
  logic              sta_wr;
  logic              dat_wr;
  logic              dat_rd;
  logic              busy;
  logic              slave_sel;
  logic              tick;
  logic              lead_ev;
  logic              trail_ev;
  logic              sample_ev;
  logic              shift_ev;
  logic              done_ev;
  logic              start_ev;
  logic              load_ev;
  logic              coll_ev;
  logic              fault_ev;
  logic              rx_in;
  logic [7:0]        sr_shifted;
  logic [7:0]        rx_byte;

  // Output bit of the shifter for the selected order.
  function automatic logic out_bit(input logic [7:0] d, input logic lsb);
    return lsb ? d[0] : d[DATA_W-1];
  endfunction : out_bit

  // Shift one received bit in at the end opposite the outgoing bit.
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
    return lsb ? {b, d[DATA_W-1:1]} : {d[DATA_W-2:0], b};
  endfunction : shift_in

  assign enable    = ctl_q[CTL_ENABLE];
  assign master    = ctl_q[CTL_MASTER];
  assign clock_polarity      = ctl_q[CTL_CLOCK_POLARITY];
  assign clock_phase      = ctl_q[CTL_CLOCK_PHASE];
  assign select_disable     = ctl_q[CTL_SELECT_DISABLE];
  assign lsb_first = ctl_q[CTL_ORDER];
  assign rate      = ctl_q[CTL_RATE_HI:CTL_RATE_LO];

  assign ctl_wr = sfr_wr && (sfr_addr == ADDR_CONTROL);
  assign sta_wr = sfr_wr && (sfr_addr == ADDR_STATUS);
  assign dat_wr = sfr_wr && (sfr_addr == ADDR_DATA);
  assign dat_rd = sfr_rd && (sfr_addr == ADDR_DATA);

  // Slave selection: the pin counts only while select disable is clear.
  assign slave_sel = enable && !master && (select_disable || !ss_n_i);

  // Busy: the running byte in master mode, the selection in slave mode.
  assign busy = master ? (state_q == ST_SHIFT) : slave_sel;

  // A mode fault needs the pin; with select disable set the pin has no effect.
  assign fault_ev = enable && master && !select_disable && !ss_n_i;

  assign coll_ev  = dat_wr && busy;
  assign load_ev  = dat_wr && !busy;
  assign start_ev = load_ev && enable && master && !fault_ev;

  // Master timing comes from the divider; the rate field plays no part in slave mode.
  sps_rate_gen #(
    .RW (RATE_W),
    .CW (DIV_CNT_W)
  ) u_rate (
    .sys_clk (sys_clk),
    .rst     (rst),
    .run     (master && (state_q == ST_SHIFT)),
    .rate    (rate),
    .tick    (tick)
  );

  // Edge classification. In slave mode the pin is sampled directly, which
  // is why the remote clock must stay at or below a quarter of sys_clk.
  always_comb begin
    if (master) begin
      lead_ev  = tick && !edge_q[0];
      trail_ev = tick && edge_q[0];
    end else begin
      lead_ev  = slave_sel && (sck_i != clock_polarity) && (sck_prev_q == clock_polarity);
      trail_ev = slave_sel && (sck_i == clock_polarity) && (sck_prev_q != clock_polarity);
    end
  end

  assign sample_ev = clock_phase ? trail_ev : lead_ev;
  assign shift_ev  = clock_phase ? lead_ev : trail_ev;

  // Master ends after the sixteenth edge; slave ends on its eighth sample edge.
  assign done_ev = master ? (tick && (edge_q == LAST_EDGE))
                          : (sample_ev && (bit_q == LAST_BIT));

  assign rx_in      = master ? miso_i : mosi_i;
  assign sr_shifted = shift_in(sr_q, rx_in, lsb_first);
  assign rx_byte    = sample_ev ? sr_shifted : sr_q;

  // Control register; a mode fault overrides a same-cycle software write.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctl_q <= CONTROL_RST;
    end else begin
      if (ctl_wr) begin
        ctl_q <= sfr_wdata;
      end
      if (fault_ev) begin
        ctl_q[CTL_ENABLE] <= 1'b0;
        ctl_q[CTL_MASTER] <= 1'b0;
      end
    end
  end

  // Master sequencer; leaving master mode or disabling the port aborts the byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_ev) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!enable || !master || done_ev) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Master edge counter.
  always_ff @(posedge sys_clk) begin
    if (rst || state_q == ST_IDLE) begin
      edge_q <= '0;
    end else if (tick) begin
      edge_q <= edge_q + 4'h1;
    end
  end

  // Sample counter; dropping the selection discards a partial slave byte.
  always_ff @(posedge sys_clk) begin
    if (rst || !enable || (!master && !slave_sel) || start_ev) begin
      bit_q <= '0;
    end else if (sample_ev) begin
      bit_q <= bit_q + 3'h1;
    end
  end

  // Generated serial clock rests at the polarity level outside a byte.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_lvl_q <= 1'b0;
    end else if (state_q != ST_SHIFT || !enable) begin
      sck_lvl_q <= clock_polarity;
    end else if (tick) begin
      sck_lvl_q <= !sck_lvl_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
    end
  end

  // Shift register: loaded by a data write while not busy, shifted on sample edges.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sr_q <= DATA_RST;
    end else if (load_ev) begin
      sr_q <= sfr_wdata;
    end else if (enable && sample_ev) begin
      sr_q <= sr_shifted;
    end
  end

  // Outgoing bit; the first bit is presented at load so phase zero can sample it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_q <= 1'b0;
    end else if (load_ev) begin
      dout_q <= out_bit(sfr_wdata, lsb_first);
    end else if (enable && shift_ev) begin
      dout_q <= out_bit(sr_q, lsb_first);
    end
  end

  // Receive buffer keeps the old byte while full.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxbuf_q <= DATA_RST;
    end else if (done_ev && !rbf_q) begin
      rxbuf_q <= rx_byte;
    end
  end

  // Flags: a hardware set in the same cycle as a clear wins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      done_flag_q <= 1'b0;
    end else if (done_ev) begin
      done_flag_q <= 1'b1;
    end else if (int_ack || (sta_wr && !sfr_wdata[STA_DONE])) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_collision_flag_q <= 1'b0;
    end else if (coll_ev) begin
      write_collision_flag_q <= 1'b1;
    end else if (load_ev || (sta_wr && !sfr_wdata[STA_WRITE_COLLISION_FLAG])) begin
      write_collision_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_fault_flag_q <= 1'b0;
    end else if (fault_ev) begin
      mode_fault_flag_q <= 1'b1;
    end else if (sta_wr && !sfr_wdata[STA_MODE_FAULT_FLAG]) begin
      mode_fault_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rbf_q <= 1'b0;
    end else if (done_ev) begin
      rbf_q <= 1'b1;
    end else if (dat_rd || (sta_wr && !sfr_wdata[STA_RBF])) begin
      rbf_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_q <= 1'b0;
    end else if (done_ev && rbf_q) begin
      ovf_q <= 1'b1;
    end else if (dat_rd || (sta_wr && !sfr_wdata[STA_OVF])) begin
      ovf_q <= 1'b0;
    end
  end

  // Read data is registered: it appears the cycle after the read strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_rdata <= READ_ZERO;
    end else if (sfr_rd) begin
      case (sfr_addr)
        ADDR_CONTROL: begin
          sfr_rdata <= ctl_q;
        end
        ADDR_STATUS: begin
          sfr_rdata <= {done_flag_q, write_collision_flag_q, mode_fault_flag_q, ovf_q, rbf_q, busy, 2'h0};
        end
        ADDR_DATA: begin
          sfr_rdata <= rxbuf_q;
        end
        default: begin
          sfr_rdata <= READ_ZERO;
        end
      endcase
    end
  end

  assign irq = int_enable && (done_flag_q || write_collision_flag_q || mode_fault_flag_q);

  // Pin drive: master owns clock and MOSI, a selected slave owns MISO.
  assign sck_o   = sck_lvl_q;
  assign sck_oe  = enable && master;
  assign mosi_o  = dout_q;
  assign mosi_oe = enable && master;
  assign miso_o  = dout_q;
  assign miso_oe = slave_sel;

endmodule : sps_port

`default_nettype wire

// File: sps_port_props.sv
`timescale 1ns/100ps
`default_nettype none

module sps_port_props
  import sps_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  // Interrupt
  input wire logic       int_enable,
  input wire logic       irq,
  // Pins
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       ss_n_i
);
  logic [7:0] ctl_q;
  logic [4:0] cnt_q;
  logic [3:0] tog_q;
  logic       sck_q;
  logic       oe_q;
  logic       tog;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Shadow of the control register; the hardware clear on a fault is not needed here.
  always_ff @(posedge sys_clk) begin
    if (rst) ctl_q <= 8'h00;
    else if (sfr_wr && sfr_addr == ADDR_CONTROL) ctl_q <= sfr_wdata;
  end

  always_ff @(posedge sys_clk) begin
    sck_q <= sck_o;
    oe_q  <= sck_oe;
  end

  assign tog = sck_oe && oe_q && (sck_o != sck_q);

  // The first toggle of a byte is timed from the data write, so only later ones are measured.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      tog_q <= 4'h0;
    end else if (tog) begin
      cnt_q <= 5'h01;
      tog_q <= tog_q + 4'h1;
    end else if (cnt_q != 5'h1f) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  property p_idle_level; !sck_oe && !oe_q && $stable(ctl_q) |-> sck_o == ctl_q[CTL_CLOCK_POLARITY]; endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock off idle level");
  property p_rate; tog && tog_q != 4'h0 |-> cnt_q == (5'h01 << ctl_q[1:0]); endproperty
  a_rate: assert property (p_rate) else $error("serial clock half period wrong");
  property p_oe_pair;
    sck_oe == mosi_oe && (!sck_oe || (ctl_q[CTL_ENABLE] && ctl_q[CTL_MASTER]));
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("master pin enables disagree");
  property p_slave_quiet;
    miso_oe && $stable(ctl_q) |-> !sck_oe && sck_o == ctl_q[CTL_CLOCK_POLARITY];
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drives clock");
  property p_deselect; !ctl_q[CTL_SELECT_DISABLE] && ss_n_i && $past(ss_n_i) && $stable(ctl_q) |-> !miso_oe;
  endproperty
  a_deselect: assert property (p_deselect) else $error("unselected slave drives");
  property p_fault; sck_oe && !ss_n_i && !ctl_q[CTL_SELECT_DISABLE] |-> ##[1:3] !sck_oe; endproperty
  a_fault: assert property (p_fault) else $error("master kept on after select low");
  property p_select_disable; sck_oe && ctl_q[CTL_SELECT_DISABLE] && !ss_n_i && !sfr_wr |=> sck_oe; endproperty
  a_select_disable: assert property (p_select_disable) else $error("disabled select caused a fault");
  property p_irq_mask; !int_enable |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while disabled");

endmodule : sps_port_props

bind sps_port sps_port_props i_sps_port_props (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
  .int_enable, .irq, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .ss_n_i);

`default_nettype wire

// File: sps_spi_slave.sv
`timescale 1ns/100ps
`default_nettype none

module sps_spi_slave (
  // Link
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Setup
  input  wire logic       sel,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic       bit_order,
  input  wire logic [7:0] tx,
  output logic      [7:0] rx
);
  logic [7:0] sh_q;
  logic       first_q;
  logic       armed_q;
  logic       cur;

  assign cur  = bit_order ? sh_q[0] : sh_q[7];
  // A released line floats; showing the inverse keeps stale data from matching by luck.
  assign miso = sel ? cur : ~cur;

  // One process owns all state, so a rising select and a clock change never race.
  // With phase set the first edge only launches the bit already on the line.
  always @(sel or sck) begin
    if (sel !== 1'b1) begin
      armed_q = 1'b0;
    end else if (armed_q !== 1'b1) begin
      armed_q = 1'b1;
      sh_q = tx;
      first_q = 1'b1;
      rx = 8'h00;
    end else if ((sck != clock_polarity) ^ clock_phase) begin
      rx = bit_order ? {mosi, rx[7:1]} : {rx[6:0], mosi};
    end else if (clock_phase && first_q) begin
      first_q = 1'b0;
    end else begin
      sh_q = bit_order ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
    end
  end

endmodule : sps_spi_slave

`default_nettype wire

// File: sps_port_tb.sv
`timescale 1ns/100ps
`default_nettype none

module sps_port_tb;
  import sps_pkg::*;

  logic       sys_clk, rst, sfr_wr, sfr_rd, int_enable, int_ack, irq, ss_n_i;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, m_tx, m_rx;
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic       t_sck, t_mosi, m_miso, sel, clock_polarity, clock_phase, bit_order, sck_w, mosi_w, miso_w;
  int         err_count = 0;
  int         checked = 0;

  assign sck_w  = sck_oe ? sck_o : t_sck;
  assign mosi_w = mosi_oe ? mosi_o : t_mosi;
  assign miso_w = miso_oe ? miso_o : m_miso;

  sps_port i_sps_port (.sys_clk, .rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .int_enable, .int_ack, .irq, .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w), .mosi_o,
    .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i);

  sps_spi_slave i_sps_spi_slave (.sck(sck_w), .mosi(mosi_w), .miso(m_miso), .sel, .clock_polarity,
    .clock_phase, .bit_order, .tx(m_tx), .rx(m_rx));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge sys_clk);
    #1 sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge sys_clk);
    #1 sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rdchk

  task automatic wait_idle;
    logic [7:0] s;
    int         n;
    n = 0;
    s = 8'hff;
    while (s[STA_BUSY] !== 1'b0 && n < 300) begin
      rd(ADDR_STATUS, s);
      n++;
    end
    if (s[STA_BUSY] !== 1'b0) chk(s, 8'h00);
  endtask : wait_idle

  // Enable goes last so the clock level settles before the pins are driven.
  task automatic cfg(input logic [7:0] v);
    clock_polarity = v[CTL_CLOCK_POLARITY];
    clock_phase = v[CTL_CLOCK_PHASE];
    bit_order = v[CTL_ORDER];
    wr(ADDR_CONTROL, v & 8'h7f);
    wr(ADDR_CONTROL, v);
  endtask : cfg

  task automatic start(input logic [7:0] d, input logic [7:0] e);
    sel = 1'b0;
    m_tx = e;
    #1 sel = 1'b1;
    wr(ADDR_DATA, d);
  endtask : start

  task automatic sbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk);
      #1 t_mosi = b[i];
      repeat (4) @(posedge sys_clk);
      #1 r[i] = miso_w;
      t_sck = 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 t_sck = 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : sbyte

  task automatic t_reset;
    rdchk(ADDR_CONTROL, CONTROL_RST);
    rdchk(ADDR_STATUS, 8'h00);
    rdchk(ADDR_DATA, DATA_RST);
    rdchk(8'hbf, READ_ZERO);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_master;
    logic [1:0] k;
    ss_n_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      cfg({2'h3, k[0], k[1], 1'h1, ^k, k});
      start(8'h1d + {k, 6'h00}, 8'hc6 - {6'h00, k});
      wait_idle;
      sel = 1'b0;
      chk(m_rx, 8'h1d + {k, 6'h00});
      rdchk(ADDR_STATUS, 8'h88);
      rdchk(ADDR_DATA, 8'hc6 - {6'h00, k});
      wr(ADDR_STATUS, 8'h00);
    end
    $display("t_master done");
  endtask : t_master

  task automatic t_overrun;
    int_enable = 1'b1;
    cfg(8'hc8);
    start(8'h81, 8'h7e);
    wr(ADDR_DATA, 8'h55);
    wait_idle;
    chk(m_rx, 8'h81);
    rdchk(ADDR_STATUS, 8'hc8);
    chk({7'h00, irq}, 8'h01);
    @(posedge sys_clk);
    #1 int_ack = 1'b1;
    @(posedge sys_clk);
    #1 int_ack = 1'b0;
    rdchk(ADDR_STATUS, 8'h48);
    start(8'h0f, 8'hf0);
    wait_idle;
    sel = 1'b0;
    rdchk(ADDR_STATUS, 8'h98);
    rdchk(ADDR_DATA, 8'h7e);
    rdchk(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'hff);
    rdchk(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
    $display("t_overrun done");
  endtask : t_overrun

  task automatic t_fault;
    ss_n_i = 1'b0;
    cfg(8'hc0);
    repeat (3) @(posedge sys_clk);
    rdchk(ADDR_CONTROL, 8'h00);
    rdchk(ADDR_STATUS, 8'h20);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_STATUS, 8'h00);
    rdchk(ADDR_STATUS, 8'h00);
    ss_n_i = 1'b1;
    int_enable = 1'b0;
    $display("t_fault done");
  endtask : t_fault

  task automatic t_slave;
    logic [7:0] r;
    cfg(8'h83);
    wr(ADDR_DATA, 8'h3c);
    sbyte(8'hff, r);
    rdchk(ADDR_STATUS, 8'h00);
    ss_n_i = 1'b0;
    rdchk(ADDR_STATUS, 8'h04);
    sbyte(8'ha5, r);
    chk(r, 8'h3c);
    ss_n_i = 1'b1;
    rdchk(ADDR_STATUS, 8'h88);
    chk({7'h00, irq}, 8'h00);
    rdchk(ADDR_DATA, 8'ha5);
    wr(ADDR_STATUS, 8'h00);
    cfg(8'h8b);
    sbyte(8'h69, r);
    rdchk(ADDR_STATUS, 8'h8c);
    rdchk(ADDR_DATA, 8'h69);
    $display("t_slave done");
  endtask : t_slave

  initial begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    int_enable = 1'b0;
    int_ack = 1'b0;
    ss_n_i = 1'b1;
    t_sck = 1'b0;
    t_mosi = 1'b0;
    sel = 1'b0;
    clock_polarity = 1'b0;
    clock_phase = 1'b0;
    bit_order = 1'b0;
    m_tx = 8'h00;
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_reset;
    t_master;
    t_overrun;
    t_fault;
    t_slave;
    print_verdict;
  end

  // The whole sequence needs well under a thousand cycles; this limit leaves ample margin.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict;
  end

endmodule : sps_port_tb

`default_nettype wire
